// ==== sfar_regs.vh ====
`ifndef SFAR_REGS_VH
`define SFAR_REGS_VH
`define SFAR_OP_READ_SLOW 8'h03
`define SFAR_OP_READ_FAST 8'h0B
`define SFAR_OP_READ_DUAL 8'h3B
`define SFAR_OP_READ_QUAD 8'h6B
`define SFAR_ADDR_WIDTH 22
`define SFAR_ADDR_TOP 22'h3FFFFF
`define SFAR_ADDR_ZERO 22'h000000
`define SFAR_OPCODE_BITS 6'h08
`define SFAR_ADDRESS_BITS 6'h18
`define SFAR_DUMMY_BITS 6'h08
`define SFAR_SLOTS_SINGLE 3'h7
`define SFAR_SLOTS_DUAL 3'h3
`define SFAR_SLOTS_QUAD 3'h1
`endif

// ==== sfar_pin_sync.v ====
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module sfar_pin_sync (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // pin
    input wire pinIn,
    // result
    output reg pinOut
);
    reg stageOne_reg;
    reg stageTwo_reg;
    reg stageThree_reg;
    parameter RESET_LEVEL = 1'b0;

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stageOne_reg <= RESET_LEVEL;
            stageTwo_reg <= RESET_LEVEL;
            stageThree_reg <= RESET_LEVEL;
            pinOut <= RESET_LEVEL;
        end else begin
            stageOne_reg <= pinIn;
            stageTwo_reg <= stageOne_reg;
            stageThree_reg <= stageTwo_reg;
            if (stageTwo_reg == stageThree_reg) begin
                pinOut <= stageThree_reg;
            end
        end
    end
endmodule // sfar_pin_sync

// ==== sfar_array_read.v ====
`timescale 1ns/1ps
`include "sfar_regs.vh"
module sfar_array_read (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // spi bus from host
    input wire chipSelectN,
    input wire serialClk,
    // io0: serial_in_io0
    input wire serialInIo0In,
    output reg serialInIo0Out,
    output reg serialInIo0Oe,
    // io1: serial_out_io1
    output reg serialOutIo1Out,
    output reg serialOutIo1Oe,
    // io2: protect_pin_io2
    output reg protectPinIo2Out,
    output reg protectPinIo2Oe,
    // io3: suspend_pin_io3
    output reg suspendPinIo3Out,
    output reg suspendPinIo3Oe,
    // status_reg_second field
    input wire quadIoEnableFlag,
    // array fetch: combinational byte at arrayAddr
    output reg [21:0] arrayAddr,
    input wire [7:0] arrayData
);
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_OPCODE = 3'd1;
    localparam [2:0] ST_ADDRESS = 3'd2;
    localparam [2:0] ST_DUMMY = 3'd3;
    localparam [2:0] ST_DATA = 3'd4;
    localparam [2:0] ST_IGNORE = 3'd5;

    localparam [1:0] MODE_SINGLE = 2'd0;
    localparam [1:0] MODE_DUAL = 2'd1;
    localparam [1:0] MODE_QUAD = 2'd2;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire csSyncN;
    wire sclkSync;
    wire io0Sync;

    sfar_pin_sync #(.RESET_LEVEL(1'b1)) csSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(chipSelectN),
        .pinOut(csSyncN)
    );
    sfar_pin_sync #(.RESET_LEVEL(1'b0)) clkSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(serialClk),
        .pinOut(sclkSync)
    );
    sfar_pin_sync #(.RESET_LEVEL(1'b0)) dataSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(serialInIo0In),
        .pinOut(io0Sync)
    );

    // ---------------------------------------------------------------
    // edge detection
    // ---------------------------------------------------------------
    reg sclkPrev_reg;
    wire sclkRise;
    wire sclkFall;
    // data, clock and select all share one sync depth, so they stay aligned
    assign sclkRise = sclkSync & ~sclkPrev_reg;
    assign sclkFall = ~sclkSync & sclkPrev_reg;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    reg [2:0] state_reg;
    reg [1:0] mode_reg;
    reg [5:0] bitCount_reg;
    reg [7:0] opcode_reg;
    reg [21:0] addrCount_reg;
    reg [23:0] addrShift_reg;
    reg [7:0] dataShift_reg;
    reg [2:0] slotCount_reg;
    reg started_reg;

    // ---------------------------------------------------------------
    // byte pacing and address stepping
    // ---------------------------------------------------------------
    function [2:0] slotsPerByte;
        input [1:0] mode;
        begin
            case (mode)
                MODE_DUAL: slotsPerByte = `SFAR_SLOTS_DUAL;
                MODE_QUAD: slotsPerByte = `SFAR_SLOTS_QUAD;
                default: slotsPerByte = `SFAR_SLOTS_SINGLE;
            endcase
        end
    endfunction

    // the wrap is a compare, so it costs no extra serial clock
    function [21:0] nextAddr;
        input [21:0] addr;
        begin
            if (addr == `SFAR_ADDR_TOP) begin
                nextAddr = `SFAR_ADDR_ZERO;
            end else begin
                nextAddr = addr + 22'h000001;
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // serial input shifters
    // ---------------------------------------------------------------
    wire [7:0] opcodeNext;
    wire [23:0] addrNext;
    assign opcodeNext = {opcode_reg[6:0], io0Sync};
    assign addrNext = {addrShift_reg[22:0], io0Sync};

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclkPrev_reg <= 1'b0;
            state_reg <= ST_IDLE;
            mode_reg <= MODE_SINGLE;
            bitCount_reg <= 6'h00;
            opcode_reg <= 8'h00;
            addrCount_reg <= 22'h000000;
            addrShift_reg <= 24'h000000;
            dataShift_reg <= 8'h00;
            slotCount_reg <= 3'd0;
            started_reg <= 1'b0;
            arrayAddr <= 22'h000000;
            serialInIo0Out <= 1'b0;
            serialInIo0Oe <= 1'b0;
            serialOutIo1Out <= 1'b0;
            serialOutIo1Oe <= 1'b0;
            protectPinIo2Out <= 1'b0;
            protectPinIo2Oe <= 1'b0;
            suspendPinIo3Out <= 1'b0;
            suspendPinIo3Oe <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkSync;
            if (csSyncN) begin
                // release every pin at once, even mid-byte
                // a cut byte is dropped; the next frame reloads the counter
                state_reg <= ST_IDLE;
                serialInIo0Oe <= 1'b0;
                serialOutIo1Oe <= 1'b0;
                protectPinIo2Oe <= 1'b0;
                suspendPinIo3Oe <= 1'b0;
                started_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        bitCount_reg <= 6'h00;
                        opcode_reg <= 8'h00;
                        if (sclkRise) begin
                            opcode_reg <= opcodeNext;
                            bitCount_reg <= 6'h01;
                            state_reg <= ST_OPCODE;
                        end
                    end
                    ST_OPCODE: begin
                        if (sclkRise) begin
                            opcode_reg <= opcodeNext;
                            bitCount_reg <= bitCount_reg + 6'h01;
                            if (bitCount_reg == `SFAR_OPCODE_BITS - 6'h01)
                            begin
                                bitCount_reg <= 6'h00;
                                state_reg <= ST_ADDRESS;
                                case (opcodeNext)
                                    `SFAR_OP_READ_SLOW,
                                    `SFAR_OP_READ_FAST:
                                        mode_reg <= MODE_SINGLE;
                                    `SFAR_OP_READ_DUAL:
                                        mode_reg <= MODE_DUAL;
                                    `SFAR_OP_READ_QUAD: begin
                                        mode_reg <= MODE_QUAD;
                                        // flag read once, at opcode end
                                        if (!quadIoEnableFlag) begin
                                            state_reg <= ST_IGNORE;
                                        end
                                    end
                                    default: state_reg <= ST_IGNORE;
                                endcase
                            end
                        end
                    end
                    ST_ADDRESS: begin
                        if (sclkRise) begin
                            addrShift_reg <= addrNext;
                            bitCount_reg <= bitCount_reg + 6'h01;
                            if (bitCount_reg == `SFAR_ADDRESS_BITS - 6'h01)
                            begin
                                bitCount_reg <= 6'h00;
                                // bits 23:22 lie beyond the array
                                addrCount_reg <= addrNext[21:0];
                                arrayAddr <= addrNext[21:0];
                                if (opcode_reg == `SFAR_OP_READ_SLOW) begin
                                    state_reg <= ST_DATA;
                                end else begin
                                    state_reg <= ST_DUMMY;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // dummy bits are clocked in but not kept
                        if (sclkRise) begin
                            bitCount_reg <= bitCount_reg + 6'h01;
                            if (bitCount_reg == `SFAR_DUMMY_BITS - 6'h01)
                            begin
                                bitCount_reg <= 6'h00;
                                state_reg <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        // drive on falling edges; first one loads the byte
                        // arrayAddr already holds this byte's address
                        // the host samples on the rise, half a clock later
                        if (sclkFall) begin
                            if (!started_reg || slotCount_reg == 3'd0)
                            begin
                                started_reg <= 1'b1;
                                slotCount_reg <= slotsPerByte(mode_reg);
                                addrCount_reg <= nextAddr(addrCount_reg);
                                arrayAddr <= nextAddr(addrCount_reg);
                                case (mode_reg)
                                    MODE_DUAL: begin
                                        serialOutIo1Out <= arrayData[7];
                                        serialInIo0Out <= arrayData[6];
                                        serialOutIo1Oe <= 1'b1;
                                        serialInIo0Oe <= 1'b1;
                                        dataShift_reg <=
                                            {arrayData[5:0], 2'b00};
                                    end
                                    MODE_QUAD: begin
                                        suspendPinIo3Out <= arrayData[7];
                                        protectPinIo2Out <= arrayData[6];
                                        serialOutIo1Out <= arrayData[5];
                                        serialInIo0Out <= arrayData[4];
                                        serialOutIo1Oe <= 1'b1;
                                        serialInIo0Oe <= 1'b1;
                                        protectPinIo2Oe <= 1'b1;
                                        suspendPinIo3Oe <= 1'b1;
                                        dataShift_reg <=
                                            {arrayData[3:0], 4'h0};
                                    end
                                    default: begin
                                        serialOutIo1Out <= arrayData[7];
                                        serialOutIo1Oe <= 1'b1;
                                        dataShift_reg <=
                                            {arrayData[6:0], 1'b0};
                                    end
                                endcase
                            end else begin
                                slotCount_reg <= slotCount_reg - 3'd1;
                                case (mode_reg)
                                    MODE_DUAL: begin
                                        serialOutIo1Out <= dataShift_reg[7];
                                        serialInIo0Out <= dataShift_reg[6];
                                        dataShift_reg <=
                                            {dataShift_reg[5:0], 2'b00};
                                    end
                                    MODE_QUAD: begin
                                        suspendPinIo3Out <= dataShift_reg[7];
                                        protectPinIo2Out <= dataShift_reg[6];
                                        serialOutIo1Out <= dataShift_reg[5];
                                        serialInIo0Out <= dataShift_reg[4];
                                        dataShift_reg <=
                                            {dataShift_reg[3:0], 4'h0};
                                    end
                                    default: begin
                                        serialOutIo1Out <= dataShift_reg[7];
                                        dataShift_reg <=
                                            {dataShift_reg[6:0], 1'b0};
                                    end
                                endcase
                            end
                        end
                    end
                    ST_IGNORE: begin
                        // pins stay released until chip select rises
                        serialInIo0Oe <= 1'b0;
                        serialOutIo1Oe <= 1'b0;
                        protectPinIo2Oe <= 1'b0;
                        suspendPinIo3Oe <= 1'b0;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // sfar_array_read

// ==== sfar_array_read_assertions.sv ====
`timescale 1ns/1ps
module sfar_array_read_assertions (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // spi bus
    input wire chipSelectN,
    input wire serialClk,
    input wire serialInIo0In,
    // io pins
    input wire serialInIo0Out,
    input wire serialInIo0Oe,
    input wire serialOutIo1Out,
    input wire serialOutIo1Oe,
    input wire protectPinIo2Out,
    input wire protectPinIo2Oe,
    input wire suspendPinIo3Out,
    input wire suspendPinIo3Oe,
    // flag and array
    input wire quadIoEnableFlag,
    input wire [21:0] arrayAddr,
    input wire [7:0] arrayData
);
    // cycles since the serial clock fell; data may only move soon after
    reg [3:0] lowCnt_reg;
    wire anyOe;
    assign anyOe = serialInIo0Oe | serialOutIo1Oe | protectPinIo2Oe
        | suspendPinIo3Oe;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            lowCnt_reg <= 4'h0;
        else if (serialClk)
            lowCnt_reg <= 4'h0;
        else if (lowCnt_reg != 4'hF)
            lowCnt_reg <= lowCnt_reg + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_CS_RELEASE: assert property (
        chipSelectN[*6] |-> !anyOe)
        else $error("pins driven with chip select high");
    AST_FALL_ON_CS: assert property (
        $fell(serialOutIo1Oe) |-> chipSelectN)
        else $error("io1 released while selected");
    AST_IO0_WITH_IO1: assert property (
        serialInIo0Oe |-> serialOutIo1Oe)
        else $error("io0 driven without io1");
    AST_QUAD_TOGETHER: assert property (
        protectPinIo2Oe || suspendPinIo3Oe |->
        protectPinIo2Oe && suspendPinIo3Oe && serialInIo0Oe)
        else $error("quad pins not driven together");
    AST_QUAD_FLAG: assert property (
        $rose(protectPinIo2Oe) |-> quadIoEnableFlag)
        else $error("quad output with enable flag clear");
    AST_DATA_AFTER_FALL: assert property (
        serialOutIo1Oe && $past(serialOutIo1Oe) && $changed(serialOutIo1Out)
        |-> !serialClk && lowCnt_reg inside {[4'h1:4'h8]})
        else $error("io1 data moved away from a falling edge");
    AST_ADDR_STEP: assert property (
        serialOutIo1Oe && $past(serialOutIo1Oe) && $changed(arrayAddr)
        |-> arrayAddr == $past(arrayAddr) + 22'h1)
        else $error("address counter did not step by one");
    AST_ADDR_RATE: assert property (
        $changed(arrayAddr) && serialOutIo1Oe |=> $stable(arrayAddr)[*8])
        else $error("address counter stepped too fast");
    COV_SINGLE: cover property ($rose(serialOutIo1Oe) && !serialInIo0Oe);
    COV_DUAL: cover property ($rose(serialInIo0Oe) && !protectPinIo2Oe);
    COV_QUAD: cover property ($rose(protectPinIo2Oe));
endmodule // sfar_array_read_assertions

bind sfar_array_read sfar_array_read_assertions chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialInIo0In(serialInIo0In),
    .serialInIo0Out(serialInIo0Out), .serialInIo0Oe(serialInIo0Oe),
    .serialOutIo1Out(serialOutIo1Out), .serialOutIo1Oe(serialOutIo1Oe),
    .protectPinIo2Out(protectPinIo2Out), .protectPinIo2Oe(protectPinIo2Oe),
    .suspendPinIo3Out(suspendPinIo3Out), .suspendPinIo3Oe(suspendPinIo3Oe),
    .quadIoEnableFlag(quadIoEnableFlag), .arrayAddr(arrayAddr),
    .arrayData(arrayData)
);

// ==== sfar_host_model.sv ====
`timescale 1ns/1ps
module sfar_host_model (
    // clock
    input wire mclk,
    // spi bus toward the device
    output reg chipSelectN,
    output reg serialClk,
    output reg hostIo0,
    // resolved pin levels
    input wire [3:0] ioLevel
);
    logic [7:0] rx[$];
    logic [7:0] shReg;
    int nBits;
    initial begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
        hostIo0 = 1'b0;
    end
    // half of a 160 ns serial clock, slow enough for every opcode
    task automatic waitHalf();
        repeat (10) @(posedge mclk);
    endtask
    // mode 0: drive while low, both sides sample on the rise
    task automatic clk1(input logic d, input int lanes);
        hostIo0 <= d;
        waitHalf();
        serialClk <= 1'b1;
        if (lanes == 1)
            shReg = {shReg[6:0], ioLevel[1]};
        else if (lanes == 2)
            shReg = {shReg[5:0], ioLevel[1:0]};
        else if (lanes == 4)
            shReg = {shReg[3:0], ioLevel};
        if (lanes != 0) begin
            nBits += lanes;
            if (nBits == 8) begin
                rx.push_back(shReg);
                nBits = 0;
            end
        end
        waitHalf();
        serialClk <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] adr,
        input int nDum, input int lanes, input int nClk);
        rx.delete();
        nBits = 0;
        chipSelectN <= 1'b0;
        waitHalf();
        for (int i = 7; i >= 0; i--) clk1(op[i], 0);
        for (int i = 23; i >= 0; i--) clk1(adr[i], 0);
        repeat (nDum) clk1(1'b0, 0);
        // io0 is released here, so it toggles instead of holding a level
        repeat (nClk) clk1(~hostIo0, lanes);
        waitHalf();
        chipSelectN <= 1'b1;
        hostIo0 <= ~hostIo0;
        waitHalf();
    endtask
endmodule // sfar_host_model

// ==== tb_sfar_array_read.sv ====
`timescale 1ns/1ps
module tb_sfar_array_read;
    logic mclk, sysRst, quadIoEnableFlag, floatPat, clrSeen;
    logic [3:0] driveSeen, oeNow, ioLevel;
    logic [7:0] arrayData;
    logic [21:0] arrayAddr;
    wire chipSelectN, serialClk, hostIo0;
    wire io0Out, io0Oe, io1Out, io1Oe, io2Out, io2Oe, io3Out, io3Oe;
    int failCount, nChecks;
    function automatic logic [7:0] memByte(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'h5A;
    endfunction
    // undriven io1 floats, io2 and io3 have pull-ups
    assign ioLevel[0] = io0Oe ? io0Out : hostIo0;
    assign ioLevel[1] = io1Oe ? io1Out : floatPat;
    assign ioLevel[2] = io2Oe ? io2Out : 1'b1;
    assign ioLevel[3] = io3Oe ? io3Out : 1'b1;
    assign oeNow = {io3Oe, io2Oe, io1Oe, io0Oe};
    assign arrayData = memByte(arrayAddr);
    sfar_array_read dut_u (
        .mclk(mclk), .sys_rst(sysRst),
        .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialInIo0In(ioLevel[0]), .serialInIo0Out(io0Out),
        .serialInIo0Oe(io0Oe), .serialOutIo1Out(io1Out),
        .serialOutIo1Oe(io1Oe), .protectPinIo2Out(io2Out),
        .protectPinIo2Oe(io2Oe), .suspendPinIo3Out(io3Out),
        .suspendPinIo3Oe(io3Oe), .quadIoEnableFlag(quadIoEnableFlag),
        .arrayAddr(arrayAddr), .arrayData(arrayData)
    );
    sfar_host_model host_u (
        .mclk(mclk), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .hostIo0(hostIo0), .ioLevel(ioLevel)
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) floatPat <= ~floatPat;
    // sticky record of driven pins, on the other edge to avoid a race
    always @(negedge mclk) driveSeen <= clrSeen ? 4'h0 : driveSeen | oeNow;
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic checkOe(input logic [3:0] got, input logic [3:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic clearSeen();
        clrSeen <= 1'b1;
        @(posedge mclk);
        clrSeen <= 1'b0;
    endtask
    task automatic runRead(input logic [7:0] op, input logic [23:0] adr,
        input int nDum, input int lanes, input int nByte,
        input logic [3:0] expOe);
        logic [21:0] a;
        clearSeen();
        host_u.frame(op, adr, nDum, lanes, nByte * 8 / lanes);
        a = adr[21:0];
        for (int i = 0; i < nByte; i++) begin
            check8(host_u.rx[i], memByte(a));
            a = a + 22'h1;
        end
        checkOe(driveSeen, expOe);
        checkOe(oeNow, 4'h0);
    endtask
    task automatic tSlow();
        runRead(8'h03, 24'h000123, 0, 1, 3, 4'h2);
    endtask
    task automatic tFastWrap();
        runRead(8'h0B, 24'h3FFFFE, 8, 1, 4, 4'h2);
    endtask
    task automatic tDual();
        runRead(8'h3B, 24'h3FFFFF, 8, 2, 3, 4'h3);
    endtask
    task automatic tQuad();
        quadIoEnableFlag <= 1'b1;
        runRead(8'h6B, 24'h0ABCDE, 8, 4, 5, 4'hF);
    endtask
    task automatic tQuadOff();
        quadIoEnableFlag <= 1'b0;
        clearSeen();
        host_u.frame(8'h6B, 24'h000040, 8, 4, 8);
        checkOe(driveSeen, 4'h0);
        clearSeen();
        host_u.frame(8'hA5, 24'h000040, 0, 1, 16);
        checkOe(driveSeen, 4'h0);
    endtask
    task automatic tAbort();
        host_u.frame(8'h03, 24'h200000, 0, 1, 11);
        check8(8'(host_u.rx.size()), 8'h01);
        check8(host_u.rx[0], memByte(22'h200000));
        checkOe(oeNow, 4'h0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        sysRst = 1'b1;
        quadIoEnableFlag = 1'b0;
        floatPat = 1'b0;
        clrSeen = 1'b0;
        driveSeen = 4'h0;
        failCount = 0;
        nChecks = 0;
        repeat (12) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (8) @(posedge mclk);
        checkOe(oeNow, 4'h0);
        tSlow();
        tFastWrap();
        tDual();
        tQuad();
        tQuadOff();
        tAbort();
        conclude();
    end
    // seven frames take about 7600 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        failCount++;
        conclude();
    end
endmodule // tb_sfar_array_read
